// ==== rtl/ebbi_pkg.sv ====
// Package of constants and types for the external bus bank interface
package ebbi_pkg;
    localparam int ADDR_W = 27;
    localparam int DATA_W = 32;
    localparam int BANKS = 8;
    localparam int BANK_SEL_W = 3;
    localparam int CYC_W = 4;
    localparam int SIZE_W = 5;
    // Boot configuration codes
    localparam logic [1:0] BOOT_NAND = 2'h0;
    localparam logic [1:0] BOOT_B0_16 = 2'h1;
    localparam logic [1:0] BOOT_B0_32 = 2'h2;
    localparam logic [1:0] BOOT_TEST = 2'h3;
    // Bus width codes
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    // Bank region: each bank spans 2**27 bytes of the 30-bit system space
    localparam int BANK_LSB = 27;
    localparam logic [CYC_W-1:0] CYC_MIN = 4'h1;
    localparam logic [SIZE_W-1:0] SIZE_FULL = 5'h1B;
    typedef enum logic [2:0] {
        EBBI_IDLE = 3'b000,
        EBBI_ACCESS = 3'b001,
        EBBI_WAIT = 3'b010,
        EBBI_DONE = 3'b011,
        EBBI_HELD = 3'b100
    } ebbi_state_e;
endpackage

// ==== rtl/ebbi_bus.sv ====
// External bus bank interface: address/data/strobe sequencer with boot straps and bus hold
// Functional notes
// - Sample boot pins after reset release; pick boot, bank0 width
// - Drive 27-bit in-bank address
// - Data bus input on read, output on write
// - Bus width selectable 8, 16 or 32
// - Assert only the addressed bank select
// - Access cycles and bank size programmable
// - Write strobe low marks write cycle
// - Read strobe low marks read cycle
// - Grant only after releasing the bus
// - Wait low holds current cycle open
module ebbi_bus
    import ebbi_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Boot straps
    input wire logic [1:0] boot_config_pins,
    output logic nand_boot,
    output logic test_mode,
    // Internal request port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [BANK_SEL_W+ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Configuration per bank (bank 0 width comes from straps)
    input wire logic [2*BANKS-1:0] bank_width,
    input wire logic [CYC_W*BANKS-1:0] bank_cycles,
    input wire logic [SIZE_W*BANKS-1:0] bank_size,
    // External memory bus
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe,
    output logic [BANKS-1:0] bank_select_n,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic bus_drive_oe,
    input wire logic cycle_extend_n,
    input wire logic bus_hold_request_n,
    output logic bus_hold_grant_n
);
    import ebbi_pkg::*;

    // ******************************
    // Pin synchronisers
    // ******************************
    logic [1:0] wait_sync, hold_sync, boot_s1, boot_s2;
    logic [1:0] next_wait_sync, next_hold_sync;
    always_comb begin
        next_wait_sync = {wait_sync[0], cycle_extend_n};
        next_hold_sync = {hold_sync[0], bus_hold_request_n};
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_sync <= 2'h3;
            hold_sync <= 2'h3;
            boot_s1 <= 2'h0;
            boot_s2 <= 2'h0;
        end else begin
            wait_sync <= next_wait_sync;
            hold_sync <= next_hold_sync;
            boot_s1 <= boot_config_pins;
            boot_s2 <= boot_s1;
        end
    end
    logic wait_low, hold_req;
    assign wait_low = !wait_sync[1];
    assign hold_req = !hold_sync[1];

    // ******************************
    // Boot strap capture
    // ******************************
    // Straps are tracked for the first four cycles after reset, then frozen;
    // the board holds them steady through reset.
    logic [1:0] boot_code, next_boot_code;
    logic boot_frozen, next_boot_frozen;
    logic [1:0] settle, next_settle;
    always_comb begin
        next_settle = settle;
        next_boot_code = boot_code;
        next_boot_frozen = boot_frozen;
        if (!boot_frozen) begin
            next_settle = settle + 2'h1;
            next_boot_code = boot_s2;
            if (settle == 2'h3) begin
                next_boot_frozen = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_code <= BOOT_B0_16;
            boot_frozen <= 1'b0;
            settle <= 2'h0;
        end else begin
            boot_code <= next_boot_code;
            boot_frozen <= next_boot_frozen;
            settle <= next_settle;
        end
    end
    // Test mode is reported only; the board must never strap it
    assign test_mode = (boot_code == BOOT_TEST);
    assign nand_boot = (boot_code == BOOT_NAND);

    // ******************************
    // Bank decode and width
    // ******************************
    logic [BANK_SEL_W-1:0] bank_idx;
    logic [BANKS-1:0] bank_hit;
    logic [ADDR_W-1:0] offset;
    assign bank_idx = req_addr[BANK_SEL_W+ADDR_W-1:BANK_LSB];
    genvar g;
    generate
        for (g = 0; g < BANKS; g++) begin : g_dec
            logic [SIZE_W-1:0] sz;
            logic in_size;
            assign sz = bank_size[g*SIZE_W +: SIZE_W];
            // Bank occupies the low 2**size bytes of its 128 MB slot
            assign in_size = (sz >= SIZE_FULL) ||
                ((req_addr[ADDR_W-1:0] >> sz) == '0);
            assign bank_hit[g] = (bank_idx == BANK_SEL_W'(g)) && in_size;
        end
    endgenerate
    assign offset = req_addr[ADDR_W-1:0];

    logic [1:0] sel_width;
    logic [CYC_W-1:0] sel_cycles;
    always_comb begin
        sel_cycles = bank_cycles[bank_idx*CYC_W +: CYC_W];
        if (sel_cycles < CYC_MIN) begin
            sel_cycles = CYC_MIN;
        end
        if (bank_idx == '0) begin
            sel_width = (boot_code == BOOT_B0_32) ? WIDTH_32 : WIDTH_16;
        end else begin
            sel_width = bank_width[2*bank_idx +: 2];
        end
    end

    // ******************************
    // Bus cycle sequencer
    // ******************************
    ebbi_state_e state, next_state;
    logic [CYC_W-1:0] cnt, next_cnt;
    logic [ADDR_W-1:0] next_mem_addr;
    logic [DATA_W-1:0] next_mem_data_out, next_rsp_rdata;
    logic [BANKS-1:0] next_bank_select_n;
    logic next_we_n, next_oe_n, next_data_oe, next_rsp_valid, is_write, next_is_write;
    logic [1:0] width_q, next_width_q;
    logic next_grant_n, next_bus_oe;

    assign req_ready = (state == EBBI_IDLE) && boot_frozen && !hold_req;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_mem_addr = mem_addr;
        next_mem_data_out = mem_data_out;
        next_rsp_rdata = rsp_rdata;
        next_bank_select_n = bank_select_n;
        next_we_n = write_strobe_n;
        next_oe_n = read_strobe_n;
        next_data_oe = mem_data_oe;
        next_rsp_valid = 1'b0;
        next_is_write = is_write;
        next_width_q = width_q;
        next_grant_n = bus_hold_grant_n;
        next_bus_oe = bus_drive_oe;
        case (state)
            EBBI_IDLE: begin
                if (hold_req && boot_frozen) begin
                    // Release every driven pin first, grant a cycle later
                    next_bus_oe = 1'b0;
                    next_data_oe = 1'b0;
                    next_state = EBBI_HELD;
                end else if (req_valid && req_ready) begin
                    next_mem_addr = offset;
                    next_bank_select_n = ~bank_hit;
                    next_is_write = req_write;
                    next_width_q = sel_width;
                    next_we_n = !req_write;
                    next_oe_n = req_write;
                    next_data_oe = req_write;
                    next_mem_data_out = req_wdata;
                    next_cnt = sel_cycles;
                    next_state = EBBI_ACCESS;
                end
            end
            EBBI_ACCESS: begin
                if (cnt > CYC_MIN) begin
                    next_cnt = cnt - CYC_MIN;
                end else begin
                    next_state = EBBI_WAIT;
                end
            end
            EBBI_WAIT: begin
                if (!wait_low) begin
                    if (!is_write) begin
                        case (width_q)
                            WIDTH_8: next_rsp_rdata = {24'h000000, mem_data_in[7:0]};
                            WIDTH_16: next_rsp_rdata = {16'h0000, mem_data_in[15:0]};
                            default: next_rsp_rdata = mem_data_in;
                        endcase
                    end
                    next_we_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_bank_select_n = '1;
                    next_state = EBBI_DONE;
                end
            end
            EBBI_DONE: begin
                next_data_oe = 1'b0;
                next_rsp_valid = 1'b1;
                next_state = EBBI_IDLE;
            end
            EBBI_HELD: begin
                next_grant_n = !hold_req;
                if (!hold_req) begin
                    next_bus_oe = 1'b1;
                    next_state = EBBI_IDLE;
                end
            end
            default: next_state = EBBI_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= EBBI_IDLE;
            cnt <= '0;
            mem_addr <= '0;
            mem_data_out <= '0;
            rsp_rdata <= '0;
            bank_select_n <= '1;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            mem_data_oe <= 1'b0;
            rsp_valid <= 1'b0;
            is_write <= 1'b0;
            width_q <= WIDTH_32;
            bus_hold_grant_n <= 1'b1;
            bus_drive_oe <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            mem_addr <= next_mem_addr;
            mem_data_out <= next_mem_data_out;
            rsp_rdata <= next_rsp_rdata;
            bank_select_n <= next_bank_select_n;
            write_strobe_n <= next_we_n;
            read_strobe_n <= next_oe_n;
            mem_data_oe <= next_data_oe;
            rsp_valid <= next_rsp_valid;
            is_write <= next_is_write;
            width_q <= next_width_q;
            bus_hold_grant_n <= next_grant_n;
            bus_drive_oe <= next_bus_oe;
        end
    end

    // ******************************
    // Checks
    // ******************************
    one_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $countones(~bank_select_n) <= 1)
        else $error("more than one bank select active");
    grant_released_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !bus_hold_grant_n |-> !bus_drive_oe && !mem_data_oe && (&bank_select_n))
        else $error("grant given while bus still driven");
    strobe_excl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !write_strobe_n |-> read_strobe_n && mem_data_oe)
        else $error("write strobe without data drive");
    read_strobe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !read_strobe_n |-> !mem_data_oe && write_strobe_n)
        else $error("read strobe with data driven");
    wait_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == EBBI_WAIT) && wait_low |=> (state == EBBI_WAIT))
        else $error("cycle ended while wait low");
    cycle_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == EBBI_IDLE) && req_valid && req_ready && !hold_req && (sel_cycles == CYC_MIN)
        |=> (state == EBBI_ACCESS) ##1 (state == EBBI_WAIT))
        else $error("access length not as programmed");
    hold_finish_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == EBBI_HELD) && !hold_req |=> bus_hold_grant_n && (state == EBBI_IDLE))
        else $error("bus not resumed after release");
    addr_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == EBBI_IDLE) && req_valid && req_ready && !hold_req
        |=> mem_addr == $past(req_addr[ADDR_W-1:0]))
        else $error("address not driven");
    boot_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        boot_frozen && (boot_code == BOOT_B0_32) && (bank_idx == '0) |-> sel_width == WIDTH_32)
        else $error("bank0 width not from straps");
endmodule

// ==== dv/ebbi_mem_model.sv ====
// Memory model for the far side of the external bus, with a slow-cycle option
module ebbi_mem_model
    import ebbi_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Memory bus
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic mem_data_oe,
    input wire logic [BANKS-1:0] bank_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    output logic [DATA_W-1:0] mem_data_in,
    output logic cycle_extend_n,
    // Cycles the memory stretches each access
    input wire logic [3:0] slow_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [0:255];
    logic [DATA_W-1:0] last_q = 32'h0;
    logic [3:0] wait_cnt = 4'h0;
    wire active = ~&bank_select_n;
    // Undriven bus toggles so a stale sample never looks right
    assign mem_data_in = (active && !read_strobe_n) ? mem[mem_addr[7:0]] : ~last_q;
    assign cycle_extend_n = !(active && wait_cnt < slow_cycles);
    always @(posedge ref_clk) begin
        last_q <= mem_data_in;
        if (active && !write_strobe_n && mem_data_oe)
            mem[mem_addr[7:0]] <= mem_data_out;
        wait_cnt <= !active ? 4'h0 : (wait_cnt == 4'hF ? wait_cnt : wait_cnt + 4'h1);
    end
endmodule

// ==== dv/external_bus_bank_interface_tb_top.sv ====
// Testbench for the external bus bank interface
module external_bus_bank_interface_tb_top;
    import ebbi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // Signals
    // ************
    logic ref_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_ready, rsp_valid;
    logic nand_boot, test_mode, mem_data_oe, write_strobe_n, read_strobe_n, bus_drive_oe;
    logic cycle_extend_n, bus_hold_grant_n, bus_hold_request_n = 1;
    logic [1:0] boot_config_pins = 2'h2;
    logic [29:0] req_addr = 30'h0;
    logic [31:0] req_wdata = 32'h0, rsp_rdata, mem_data_in, mem_data_out, rd;
    logic [26:0] mem_addr, addr_seen;
    logic [7:0] bank_select_n, sel_seen;
    logic [3:0] slow = 4'h0;
    logic we_seen, re_seen, oe_seen, bad_grant = 0;
    // Bank 1 is 8 bits, bank 2 is 16 bits, the rest 32 bits
    logic [15:0] bank_width = 16'hAA92;
    // Bank 1 programs zero cycles, which must act as one
    logic [31:0] bank_cycles = 32'h2222_2202;
    // Bank 5 spans only 256 bytes so that an access past it selects nothing
    logic [39:0] bank_size = {{2{SIZE_FULL}}, 5'h08, {5{SIZE_FULL}}};
    int n_fail = 0, compares = 0, lat;
    int sel_cnt = 0, sel_before;
    always #5 ref_clk = ~ref_clk;
    ebbi_bus i_ebbi_bus(.ref_clk(ref_clk), .rst_n(rst_n), .boot_config_pins(boot_config_pins),
        .nand_boot(nand_boot), .test_mode(test_mode), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .bank_width(bank_width), .bank_cycles(bank_cycles), .bank_size(bank_size),
        .mem_addr(mem_addr), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe), .bank_select_n(bank_select_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .bus_drive_oe(bus_drive_oe), .cycle_extend_n(cycle_extend_n),
        .bus_hold_request_n(bus_hold_request_n), .bus_hold_grant_n(bus_hold_grant_n));
    ebbi_mem_model i_ebbi_mem_model(.ref_clk(ref_clk), .mem_addr(mem_addr),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .bank_select_n(bank_select_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .mem_data_in(mem_data_in), .cycle_extend_n(cycle_extend_n), .slow_cycles(slow));
    // Snapshot of the bus while a bank is selected
    always @(negedge ref_clk) begin
        if (~&bank_select_n) begin
            sel_seen <= bank_select_n;
            sel_cnt <= sel_cnt + 1;
            addr_seen <= mem_addr;
            we_seen <= write_strobe_n;
            re_seen <= read_strobe_n;
            oe_seen <= mem_data_oe;
        end
        if (!bus_hold_grant_n && (~&bank_select_n || bus_drive_oe))
            bad_grant <= 1;
    end
    // ************
    // Tasks
    // ************
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_reset(logic [1:0] code);
        int n;
        @(negedge ref_clk);
        rst_n = 0;
        boot_config_pins = code;
        repeat (4) @(negedge ref_clk);
        rst_n = 1;
        for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    endtask
    task automatic access(logic w, logic [2:0] bank, logic [26:0] off, logic [31:0] d);
        int n;
        @(negedge ref_clk);
        req_valid = 1;
        req_write = w;
        req_addr = {bank, off};
        req_wdata = d;
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge ref_clk);
        @(negedge ref_clk);
        req_valid = 0;
        for (lat = 1; lat < 200 && rsp_valid !== 1'b1; lat++) @(negedge ref_clk);
        check("rsp_timeout", lat < 200, 1);
        rd = rsp_rdata;
    endtask
    task automatic t_boot();
        logic [1:0] c;
        // Code 11 is fabrication only and never strapped here
        for (int i = 0; i < 3; i++) begin
            c = 2'(i);
            do_reset(c);
            check("nand_boot", nand_boot, c == BOOT_NAND);
            check("test_mode", test_mode, 0);
        end
    endtask
    task automatic t_write_read();
        access(1, 3'h3, 27'h00000A5, 32'hA5C3_1E07);
        check("sel_wr", sel_seen, 8'hF7);
        check("addr_wr", addr_seen, 27'h00000A5);
        check("we_wr", we_seen, 0);
        check("oe_wr", oe_seen, 1);
        check("lat_min", lat >= 5, 1);
        access(0, 3'h3, 27'h00000A5, 32'h0);
        check("rd_data", rd, 32'hA5C3_1E07);
        check("re_rd", re_seen, 0);
        check("we_rd", we_seen, 1);
        check("oe_rd", oe_seen, 0);
    endtask
    task automatic t_widths();
        i_ebbi_mem_model.mem[8'h10] = 32'h1234_5678;
        access(0, 3'h1, 27'h0000010, 32'h0);
        check("rd_8b", rd, 32'h0000_0078);
        check("lat_b1", lat, 4);
        access(0, 3'h2, 27'h0000010, 32'h0);
        check("rd_16b", rd, 32'h0000_5678);
        access(0, 3'h0, 27'h0000010, 32'h0);
        check("rd_b0_32b", rd, 32'h1234_5678);
        check("sel_b0", sel_seen, 8'hFE);
        access(0, 3'h5, 27'h0000010, 32'h0);
        check("rd_b5", rd, 32'h1234_5678);
        check("sel_b5", sel_seen, 8'hDF);
        sel_before = sel_cnt;
        access(0, 3'h5, 27'h0000100, 32'h0);
        check("sel_miss", sel_cnt, sel_before);
        do_reset(BOOT_B0_16);
        access(0, 3'h0, 27'h0000010, 32'h0);
        check("rd_b0_16b", rd, 32'h0000_5678);
    endtask
    task automatic t_wait();
        slow = 4'h6;
        access(0, 3'h3, 27'h00000A5, 32'h0);
        check("lat_wait", lat >= 9, 1);
        check("rd_wait", rd, 32'hA5C3_1E07);
    endtask
    task automatic t_hold();
        int n;
        slow = 4'h4;
        fork
            access(1, 3'h4, 27'h0000033, 32'h0F0F_55AA);
            begin
                repeat (2) @(negedge ref_clk);
                bus_hold_request_n = 0;
            end
        join
        for (n = 0; n < 20 && bus_hold_grant_n !== 1'b0; n++) @(negedge ref_clk);
        check("grant", bus_hold_grant_n, 0);
        check("drive_off", bus_drive_oe, 0);
        repeat (4) @(negedge ref_clk);
        check("ready_held", req_ready, 0);
        check("grant_order", bad_grant, 0);
        bus_hold_request_n = 1;
        for (n = 0; n < 20 && bus_hold_grant_n !== 1'b1; n++) @(negedge ref_clk);
        check("drive_back", bus_drive_oe, 1);
        slow = 4'h0;
        access(0, 3'h4, 27'h0000033, 32'h0);
        check("rd_after_hold", rd, 32'h0F0F_55AA);
    endtask
    // ************
    // Sequence
    // ************
    initial begin
        t_boot();
        t_write_read();
        t_widths();
        t_wait();
        t_hold();
        finish_test();
    end
    initial begin
        #100us;
        n_fail++;
        finish_test();
    end
endmodule
